// file: design/fsbr_core.v
/*
  Synchronous burst-read output control of a parallel NOR flash: latency
  count, end-of-wordline stalls, stall-line polarity/delay/float and
  linear burst ordering, with a Wishbone read configuration register.
  Assumes the host drives flash clock and strobes as pins, and the array
  side answers array_addr_o combinationally on array_data_i.
*/
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "fsbr_consts.vh"
module fsbr_core #(
  parameter AW = 24
) (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [`FSBR_ADR_W-1:0] wb_adr_i,
  input  wire [3:0]             wb_sel_i,
  input  wire [31:0]            wb_dat_i,
  output wire [31:0]            wb_dat_o,
  output wire                   wb_ack_o,
  input  wire                   flash_clk_i,
  input  wire                   addr_valid_n_i,
  input  wire                   chip_enable_n_i,
  input  wire                   output_enable_n_i,
  input  wire                   reset_in_n_i,
  input  wire [AW-1:0]          addr_i,
  output wire [15:0]            data_bus_o,
  output wire                   data_bus_oe_o,
  output wire                   wait_o,
  output wire                   wait_oe_o,
  output wire [AW-1:0]          array_addr_o,
  input  wire [15:0]            array_data_i,
  output wire                   nonarray_o
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_LAT   = 2'h1;
  localparam [1:0] ST_DATA  = 2'h2;
  localparam [1:0] ST_STALL = 2'h3;
  localparam       SW       = AW + 5;

  // Read configuration fields
  reg        read_mode_sel_q;
  reg [3:0]  latency_count_q;
  reg        wait_polarity_q;
  reg        wait_delay_sel_q;
  reg        clock_edge_sel_q;
  reg        burst_wrap_disable_q;
  reg [2:0]  burst_length_sel_q;
  reg        nonarray_q;

  // Bus slave state
  reg        ack_q;
  reg [31:0] rdat_q;

  // Pin sampling
  wire [SW-1:0] pin_s;
  wire          fclk_s;
  wire          adv_n_s;
  wire          ce_n_s;
  wire          oe_n_s;
  wire          rst_n_s;
  wire [AW-1:0] addr_s;
  reg           fclk_q;

  // Burst engine state
  reg [1:0]     st_q;
  reg [1:0]     st_d;
  reg [3:0]     cnt_q;
  reg [3:0]     cnt_d;
  reg [AW-1:0]  cur_q;
  reg [AW-1:0]  cur_d;
  reg [AW-1:0]  start_q;
  reg [AW-1:0]  start_d;
  reg [4:0]     words_q;
  reg [4:0]     words_d;
  reg           end_of_wordline_stall_q;
  reg           end_of_wordline_stall_d;
  reg [15:0]    data_q;
  reg [15:0]    data_d;
  reg           wait_q;
  reg           wait_d;
  reg           present;
  reg           look;

  wire          edge_rise;
  wire          edge_fall;
  wire          valid_edge;
  wire          step;
  wire          bus_act;
  wire [3:0]    lc_eff;
  wire [3:0]    lc_m1;
  reg  [3:0]    stall_n;
  reg  [4:0]    burst_len;
  reg           cont;
  wire          wrap_act;
  wire [3:0]    wrap_mask;
  wire [AW-1:0] nxt;
  wire          burst_end;
  wire          row_cross;

  // Every pin is a foreign level; reset values mirror a deselected bus held in flash reset
  fsbr_sync #(
    .W       (SW),
    .RST_VAL ({1'b0, 1'b1, 1'b1, 1'b1, 1'b0, {AW{1'b0}}})
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({flash_clk_i, addr_valid_n_i, chip_enable_n_i, output_enable_n_i, reset_in_n_i, addr_i}),
    .q_o   (pin_s)
  );

  assign fclk_s  = pin_s[AW+4];
  assign adv_n_s = pin_s[AW+3];
  assign ce_n_s  = pin_s[AW+2];
  assign oe_n_s  = pin_s[AW+1];
  assign rst_n_s = pin_s[AW];
  assign addr_s  = pin_s[AW-1:0];

  // Flash clock edge detection on the filtered copy
  always @(posedge clk_i) begin
    if (rst_i) begin
      fclk_q <= 1'b0;
    end else begin
      fclk_q <= fclk_s;
    end
  end

  assign edge_rise  = fclk_s & ~fclk_q;
  assign edge_fall  = ~fclk_s & fclk_q;
  assign valid_edge = clock_edge_sel_q ? edge_rise : edge_fall;
  assign step       = valid_edge & ~ce_n_s & rst_n_s;
  assign bus_act    = ~ce_n_s & ~oe_n_s & rst_n_s;

  // Codes 0 and 1 are unsupported; they run as the smallest legal count
  assign lc_eff = (latency_count_q < `FSBR_LC_MIN) ? `FSBR_LC_MIN : latency_count_q;
  assign lc_m1  = lc_eff - 4'h1;

  // Burst length decode; reserved codes behave as continuous
  always @* begin
    cont = 1'b0;
    case (burst_length_sel_q)
      `FSBR_BL_4:  burst_len = `FSBR_LEN_4;
      `FSBR_BL_8:  burst_len = `FSBR_LEN_8;
      `FSBR_BL_16: burst_len = `FSBR_LEN_16;
      default: begin
        burst_len = `FSBR_LEN_16;
        cont      = 1'b1;
      end
    endcase
  end

  // Stall length grows with the start offset in its 4-word group, capped at count-1
  always @* begin
    case (start_q[1:0])
      2'h0:    stall_n = 4'h0;
      2'h3:    stall_n = lc_m1;
      default: stall_n = ({2'h0, start_q[1:0]} < lc_m1) ? {2'h0, start_q[1:0]} : lc_m1;
    endcase
  end

  // Linear ordering only: wrap modulo length or plain increment
  assign wrap_act  = ~burst_wrap_disable_q & ~cont;
  assign wrap_mask = burst_len[3:0] - 4'h1;
  assign nxt = wrap_act ?
               {cur_q[AW-1:`FSBR_ROW_LSB_W], (cur_q[3:0] & ~wrap_mask) | ((cur_q[3:0] + 4'h1) & wrap_mask)} :
               cur_q + {{(AW-1){1'b0}}, 1'b1};

  assign burst_end = ~cont & (words_q == burst_len);
  assign row_cross = (cur_q[3:0] == 4'h0) & ~end_of_wordline_stall_q;

  // Burst engine next state; a burst advances only on valid clock edges of a selected chip
  always @* begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    cur_d   = cur_q;
    start_d = start_q;
    words_d = words_q;
    end_of_wordline_stall_d  = end_of_wordline_stall_q;
    data_d  = data_q;
    wait_d  = wait_q;
    present = 1'b0;
    look    = 1'b0;
    if (read_mode_sel_q) begin
      // Asynchronous reads follow the latched address every cycle
      st_d   = ST_IDLE;
      data_d = array_data_i;
      if (~adv_n_s) begin
        cur_d = addr_s;
      end
    end else if (step) begin
      if (~adv_n_s) begin
        start_d = addr_s;
        cur_d   = addr_s;
        cnt_d   = lc_m1;
        words_d = 5'h00;
        end_of_wordline_stall_d  = (addr_s[3:0] == 4'h0) | wrap_act;
        st_d    = ST_LAT;
      end else begin
        case (st_q)
          ST_LAT, ST_STALL: begin
            if (cnt_q == 4'h1) begin
              present = 1'b1;
            end else begin
              cnt_d = cnt_q - 4'h1;
            end
          end
          ST_DATA: begin
            if (burst_end) begin
              st_d = ST_IDLE;
            end else if (row_cross) begin
              // Stall happens at most once per burst
              end_of_wordline_stall_d = 1'b1;
              if (stall_n != 4'h0) begin
                cnt_d = stall_n;
                st_d  = ST_STALL;
              end else begin
                present = 1'b1;
              end
            end else begin
              present = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (present) begin
        data_d = array_data_i;
        cur_d  = nxt;
        st_d   = ST_DATA;
        if (words_q != `FSBR_WORDS_MAX) begin
          words_d = words_q + 5'h01;
        end
      end
      // Will the following valid edge hold valid data?
      case (st_d)
        ST_DATA:  look = (~cont & (words_d == burst_len)) | ~((cur_d[3:0] == 4'h0) & ~end_of_wordline_stall_d & (stall_n != 4'h0));
        ST_LAT:   look = (cnt_d == 4'h1);
        ST_STALL: look = (cnt_d == 4'h1);
        default:  look = 1'b0;
      endcase
      // Idle after a finished burst still carries the last valid word
      if (wait_delay_sel_q) begin
        wait_d = ~(look | ((st_d == ST_IDLE) & (words_d != 5'h00)));
      end else begin
        wait_d = ~((st_d == ST_DATA) | ((st_d == ST_IDLE) & (words_d != 5'h00)));
      end
    end
    // Deselect or flash reset abandons the burst
    if (ce_n_s | ~rst_n_s) begin
      st_d   = ST_IDLE;
      wait_d = 1'b1;
    end
  end

  // Burst engine registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      cur_q   <= {AW{1'b0}};
      start_q <= {AW{1'b0}};
      words_q <= 5'h00;
      end_of_wordline_stall_q  <= 1'b1;
      data_q  <= 16'h0000;
      wait_q  <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      cur_q   <= cur_d;
      start_q <= start_d;
      words_q <= words_d;
      end_of_wordline_stall_q  <= end_of_wordline_stall_d;
      data_q  <= data_d;
      wait_q  <= wait_d;
    end
  end

  // Pin drivers; both float unless chip and output are enabled and flash reset is released
  assign data_bus_o    = data_q;
  assign data_bus_oe_o = bus_act;
  assign wait_oe_o     = bus_act;
  // Asserted level is the polarity bit; async mode shows the idle level
  assign wait_o = (read_mode_sel_q | ~wait_q) ? ~wait_polarity_q : wait_polarity_q;
  assign array_addr_o = cur_q;
  assign nonarray_o   = nonarray_q;

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      if (wb_cyc_i & wb_stb_i & ~ack_q) begin
        case (wb_adr_i)
          `FSBR_CFG_OFS: begin
            rdat_q <= 32'h00000000;
            rdat_q[`FSBR_RM_BIT]             <= read_mode_sel_q;
            rdat_q[`FSBR_LC_HI:`FSBR_LC_LO]  <= latency_count_q;
            rdat_q[`FSBR_WP_BIT]             <= wait_polarity_q;
            rdat_q[`FSBR_WD_BIT]             <= wait_delay_sel_q;
            rdat_q[`FSBR_BS_BIT]             <= 1'b0;
            rdat_q[`FSBR_CE_BIT]             <= clock_edge_sel_q;
            rdat_q[`FSBR_BW_BIT]             <= burst_wrap_disable_q;
            rdat_q[`FSBR_BL_HI:`FSBR_BL_LO]  <= burst_length_sel_q;
            rdat_q[`FSBR_NA_BIT]             <= nonarray_q;
          end
          `FSBR_STAT_OFS: rdat_q <= {24'h000000, words_q, wait_q, st_q};
          default:        rdat_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Configuration writes land on the edge that the master sees ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      read_mode_sel_q      <= 1'b1;
      latency_count_q      <= `FSBR_LC_RST;
      wait_polarity_q      <= 1'b1;
      wait_delay_sel_q     <= 1'b1;
      clock_edge_sel_q     <= 1'b1;
      burst_wrap_disable_q <= 1'b1;
      burst_length_sel_q   <= `FSBR_BL_RST;
      nonarray_q           <= 1'b0;
    end else if (wb_cyc_i & wb_stb_i & wb_we_i & ack_q & (wb_adr_i == `FSBR_CFG_OFS)) begin
      if (wb_sel_i[0]) begin
        read_mode_sel_q  <= wb_dat_i[`FSBR_RM_BIT];
        latency_count_q  <= wb_dat_i[`FSBR_LC_HI:`FSBR_LC_LO];
        wait_polarity_q  <= wb_dat_i[`FSBR_WP_BIT];
        wait_delay_sel_q <= wb_dat_i[`FSBR_WD_BIT];
      end
      if (wb_sel_i[1]) begin
        clock_edge_sel_q     <= wb_dat_i[`FSBR_CE_BIT];
        burst_wrap_disable_q <= wb_dat_i[`FSBR_BW_BIT];
        burst_length_sel_q   <= wb_dat_i[`FSBR_BL_HI:`FSBR_BL_LO];
        nonarray_q           <= wb_dat_i[`FSBR_NA_BIT];
      end
    end
  end

endmodule

// file: design/fsbr_consts.vh
/*
  Shared constants of the synchronous burst-read output control: register
  offsets and field positions, reset values and burst encodings.
  Assumes the word-addressed flash pins and a 32-bit classic Wishbone slave.
*/
// Operation
// - First burst word appears latency_count valid clock edges after the address strobe.
// - Unaligned start (address bits 3:0 nonzero) may cause end-of-wordline stall states.
// - Stall states after wordline end number zero to latency_count minus one; counts 2-15.
// - Stall line asserts high when wait_polarity set, low when cleared.
// - Stall line changes only on valid clock edges during an active bus cycle.
// - In synchronous mode with wait_delay_sel cleared, stall stays asserted until valid data is on the bus.
// - Synchronous non-array reads deassert stall with the same timing as array reads.
// - Non-array reads across wordline end behave correctly only on first access.
// - Asynchronous reads drive the stall line at its deasserted level.
// - Writes with output_enable_n high leave the stall line floating.
// - wait_delay_sel set deasserts stall one data cycle early; cleared, with data.
// - Only linear burst ordering exists; burst_sequence_sel reads back linear.
// - Wrapping 4/8/16 bursts count modulo length inside their aligned block.
// - No-wrap and continuous bursts increment straight across block boundaries.
// - read_mode_sel set selects asynchronous page reads, cleared synchronous bursts.
// - clock_edge_sel picks rising (default) or falling edge for data and stall.
// - Non-wrapping bursts starting 4-word aligned get no boundary delay.
`ifndef FSBR_CONSTS_VH
`define FSBR_CONSTS_VH

`define FSBR_ADR_W      8
`define FSBR_CFG_OFS    8'h00
`define FSBR_STAT_OFS   8'h04

`define FSBR_RM_BIT     0
`define FSBR_LC_LO      1
`define FSBR_LC_HI      4
`define FSBR_WP_BIT     5
`define FSBR_WD_BIT     6
`define FSBR_BS_BIT     7
`define FSBR_CE_BIT     8
`define FSBR_BW_BIT     9
`define FSBR_BL_LO      10
`define FSBR_BL_HI      12
`define FSBR_NA_BIT     13

`define FSBR_LC_RST     4'h3
`define FSBR_LC_MIN     4'h2
`define FSBR_BL_RST     3'h7
`define FSBR_BL_4       3'h1
`define FSBR_BL_8       3'h2
`define FSBR_BL_16      3'h3
`define FSBR_LEN_4      5'h04
`define FSBR_LEN_8      5'h08
`define FSBR_LEN_16     5'h10
`define FSBR_WORDS_MAX  5'h1F
`define FSBR_ROW_LSB_W  4

`endif

// file: design/fsbr_sync.v
/*
  Three-stage input synchroniser for a vector of pins; a bit changes only
  once the second and third stages agree.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ps
module fsbr_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      // Stage one feeds stage two only; agreement of two and three filters glitches
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_q  <= RST_VAL[g];
          s2_q  <= RST_VAL[g];
          s3_q  <= RST_VAL[g];
          out_q <= RST_VAL[g];
        end else begin
          s1_q <= d_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign q_o[g] = out_q;
    end
  endgenerate

endmodule

// file: verification/fsbr_core_monitor.sv
/* Checker on the ports of fsbr_core.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module fsbr_core_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        chip_enable_n_i,
  input wire        output_enable_n_i,
  input wire        reset_in_n_i,
  input wire        data_bus_oe_o,
  input wire        wait_o,
  input wire        wait_oe_o,
  input wire        nonarray_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pending request, and a read whose answer is on the bus
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_done;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (s_rd_done and (wb_adr_i[7:3] != 5'h00) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_seq_linear: assert property (s_rd_done and (wb_adr_i == 8'h00) |-> !wb_dat_o[7])
    else $error("burst sequence field not linear");
  // Pins pass a synchroniser, so floating follows a held pin within six cycles
  a_oe_float: assert property (output_enable_n_i [*6] |-> !wait_oe_o)
    else $error("stall line driven with output disabled");
  a_ce_float: assert property (chip_enable_n_i [*6] |-> !wait_oe_o && !data_bus_oe_o)
    else $error("pins driven while deselected");
  // Selected, output enabled and out of flash reset: both pins driven once synced
  a_read_drive: assert property ((!chip_enable_n_i && !output_enable_n_i && reset_in_n_i) [*6] |->
                                 wait_oe_o && data_bus_oe_o)
    else $error("pins floating in an enabled read");
  a_reset_idle: assert property ($fell(rst_i) |-> !wb_ack_o && !wait_oe_o && !wait_o && !nonarray_o)
    else $error("outputs not idle after reset");
endmodule

// file: verification/fsbr_host_model.sv
/* Host memory controller model: drives the flash pins for one burst and
   records stall line and data once per flash clock.
   Assumes clk_i is the system clock; a flash clock spans 16 of them. */
`timescale 1ns/1ps
module fsbr_host_model (
  input  wire        clk_i,
  input  wire [15:0] data_bus_i,
  input  wire        wait_i,
  input  wire        data_bus_oe_i,
  input  wire        wait_oe_i,
  output reg         flash_clk_o,
  output reg         addr_valid_n_o,
  output reg         chip_enable_n_o,
  output reg         output_enable_n_o,
  output reg         reset_in_n_o,
  output reg  [23:0] addr_o
);
  logic [15:0] dq [1:48];
  logic        wt [1:48];
  // Idle: deselected, clock still, device out of reset
  initial begin
    flash_clk_o       = 1'h0;
    addr_valid_n_o    = 1'h1;
    chip_enable_n_o   = 1'h1;
    output_enable_n_o = 1'h1;
    reset_in_n_o      = 1'h1;
    addr_o            = 24'h000000;
  end
  task automatic pins(input logic ce, input logic oe, input logic adv, input logic [23:0] a);
    @(posedge clk_i);
    chip_enable_n_o   <= ce;
    output_enable_n_o <= oe;
    addr_valid_n_o    <= adv;
    addr_o            <= a;
  endtask
  // Slow flash clock leaves ample access time for any latency count
  task automatic burst(input logic [23:0] a, input int n);
    int k;
    pins(1'h0, 1'h0, 1'h0, a);
    repeat (8) @(posedge clk_i);
    for (k = 1; k <= n; k++) begin
      flash_clk_o <= 1'h1;
      repeat (8) @(posedge clk_i);
      flash_clk_o <= 1'h0;
      repeat (4) @(posedge clk_i);
      // Strobe spans the first edge of either polarity, so both edge selects start here
      addr_valid_n_o <= 1'h1;
      addr_o         <= ~a;
      repeat (3) @(posedge clk_i);
      // A floating pin reads back inverted, so a float never passes for data
      dq[k] = data_bus_oe_i ? data_bus_i : ~data_bus_i;
      wt[k] = wait_oe_i ? wait_i : ~wait_i;
      @(posedge clk_i);
    end
    chip_enable_n_o   <= 1'h1;
    output_enable_n_o <= 1'h1;
  endtask
endmodule

// file: verification/fsbr_core_bench.sv
/* Self-checking bench for fsbr_core: configuration access, async reads,
   synchronous bursts with stalls, and pin floating.
   Assumes fsbr_host_model drives the flash pins; the array answers here. */
`timescale 1ns/1ps
module fsbr_core_bench;
  logic        clk_i    = 1'h0;
  logic        rst_i    = 1'h1;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i  = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [15:0] array_data_i;
  wire  [31:0] wb_dat_o;
  wire  [23:0] addr_i, array_addr_o;
  wire  [15:0] data_bus_o;
  wire         wb_ack_o, flash_clk_i, addr_valid_n_i, chip_enable_n_i, output_enable_n_i, reset_in_n_i;
  wire         data_bus_oe_o, wait_o, wait_oe_o, nonarray_o;
  int          num_errors = 0;
  int          n_checks   = 0;
  function automatic logic [15:0] arr(input logic [23:0] a);
    arr = a[15:0] ^ 16'h5A00;
  endfunction
  always #12.5 clk_i = ~clk_i;
  // Array answers its address in the same cycle
  always @* array_data_i = arr(array_addr_o);
  fsbr_core fsbr_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_clk_i(flash_clk_i), .addr_valid_n_i(addr_valid_n_i),
    .chip_enable_n_i(chip_enable_n_i), .output_enable_n_i(output_enable_n_i), .reset_in_n_i(reset_in_n_i),
    .addr_i(addr_i), .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o), .wait_o(wait_o),
    .wait_oe_o(wait_oe_o), .array_addr_o(array_addr_o), .array_data_i(array_data_i), .nonarray_o(nonarray_o));
  fsbr_host_model fsbr_host_model_i (.clk_i(clk_i), .data_bus_i(data_bus_o), .wait_i(wait_o),
    .data_bus_oe_i(data_bus_oe_o), .wait_oe_i(wait_oe_o),
    .flash_clk_o(flash_clk_i), .addr_valid_n_o(addr_valid_n_i), .chip_enable_n_o(chip_enable_n_i),
    .output_enable_n_o(output_enable_n_i), .reset_in_n_o(reset_in_n_i), .addr_o(addr_i));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One classic Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'h1) break;
    end
    if (i == 20) begin
      num_errors++;
      complete_run();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] lc, input logic wp, wd, bw,
                                      input logic [2:0] bl, input logic rm);
    cfg = {18'h0, 1'h0, bl, bw, 1'h1, 1'h0, wd, wp, lc, rm};
  endfunction
  function automatic logic [23:0] nxt(input logic [23:0] st, input int i, input logic wr, input logic [2:0] bl);
    logic [23:0] m;
    m = (bl == 3'h1) ? 24'h3 : (bl == 3'h2) ? 24'h7 : 24'hF;
    nxt = (wr && bl != 3'h7) ? ((st & ~m) | ((st + 24'(i)) & m)) : st + 24'(i);
  endfunction
  task automatic sc_regs();
    logic [31:0] q;
    wb(1'h0, 8'h00, 32'h0, q);
    chk("cfg reset", q, 32'h00001F67);
    wb(1'h1, 8'h00, 32'h00003FFF, q);
    wb(1'h0, 8'h00, 32'h0, q);
    chk("cfg readback", q, 32'h00003F7F);
    chk("nonarray select", nonarray_o, 1'h1);
    wb(1'h1, 8'h08, 32'hFFFFFFFF, q);
    wb(1'h0, 8'h08, 32'h0, q);
    chk("unmapped read", q, 32'h0);
    wb(1'h0, 8'h04, 32'h0, q);
    chk("status idle", q & 32'h3, 32'h0);
  endtask
  // Async reads in both polarities, then floating with output disabled
  task automatic sc_async();
    logic [31:0] q;
    int p;
    for (p = 0; p < 2; p++) begin
      wb(1'h1, 8'h00, cfg(4'h3, p[0], 1'h1, 1'h1, 3'h7, 1'h1), q);
      fsbr_host_model_i.pins(1'h0, 1'h0, 1'h0, 24'h000123);
      repeat (12) @(posedge clk_i);
      chk("async word", data_bus_o, arr(24'h000123));
      chk("async stall level", wait_o, !p[0]);
      chk("stall driven", wait_oe_o, 1'h1);
      fsbr_host_model_i.reset_in_n_o <= 1'h0;
      repeat (8) @(posedge clk_i);
      chk("float in flash reset", {wait_oe_o, data_bus_oe_o}, 2'h0);
      fsbr_host_model_i.reset_in_n_o <= 1'h1;
      fsbr_host_model_i.pins(1'h0, 1'h1, 1'h1, 24'hFFFEDC);
      repeat (8) @(posedge clk_i);
      chk("float on write", {wait_oe_o, data_bus_oe_o}, 2'h0);
      fsbr_host_model_i.pins(1'h1, 1'h1, 1'h1, 24'hFFFEDC);
    end
  endtask
  // Sync burst: data is valid at edge k when the stall line was released at edge k - wd
  task automatic sc_burst(input logic [23:0] st, input logic [3:0] lc, input logic wp, wd, wr,
                          input logic [2:0] bl, input int n, input int stl, input logic na, fe);
    logic [31:0] q;
    int k, got, last;
    got  = 0;
    last = 0;
    wb(1'h1, 8'h00, (cfg(lc, wp, wd, ~wr, bl, 1'h0) | {18'h0, na, 13'h0}) ^ {23'h0, fe, 8'h0}, q);
    chk("nonarray select", nonarray_o, na);
    fsbr_host_model_i.burst(st, lc + n + stl + 2);
    for (k = 1; k <= lc + n + stl + 2; k++) begin
      if (k > wd && got < n && fsbr_host_model_i.wt[k - wd] === ~wp) begin
        if (got == 0) chk("first word edge", k, lc);
        chk("burst word", fsbr_host_model_i.dq[k], arr(nxt(st, got, wr, bl)));
        got++;
        last = k;
      end
    end
    chk("last word edge", last, lc + n - 1 + stl);
    chk("stall at start", fsbr_host_model_i.wt[1], wp);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    sc_regs();
    sc_async();
    sc_burst(24'h000002, 4'h3, 1'h1, 1'h0, 1'h1, 3'h1, 4, 0, 1'h0, 1'h0);
    sc_burst(24'h000005, 4'h4, 1'h0, 1'h1, 1'h1, 3'h2, 8, 0, 1'h0, 1'h0);
    sc_burst(24'h00000E, 4'h2, 1'h1, 1'h0, 1'h1, 3'h3, 16, 0, 1'h0, 1'h0);
    sc_burst(24'h00000E, 4'h4, 1'h0, 1'h0, 1'h0, 3'h7, 6, 2, 1'h0, 1'h0);
    sc_burst(24'h000013, 4'h3, 1'h1, 1'h0, 1'h0, 3'h3, 16, 2, 1'h0, 1'h0);
    sc_burst(24'h00001C, 4'h5, 1'h1, 1'h0, 1'h0, 3'h2, 8, 0, 1'h0, 1'h0);
    sc_burst(24'h000004, 4'h3, 1'h1, 1'h0, 1'h0, 3'h7, 4, 0, 1'h1, 1'h0);
    sc_burst(24'h000009, 4'h3, 1'h1, 1'h1, 1'h0, 3'h7, 10, 1, 1'h0, 1'h1);
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    #(25 * 90000);
    num_errors++;
    complete_run();
  end
endmodule
bind fsbr_core fsbr_core_monitor fsbr_core_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .chip_enable_n_i(chip_enable_n_i), .output_enable_n_i(output_enable_n_i), .data_bus_oe_o(data_bus_oe_o),
  .wait_o(wait_o), .wait_oe_o(wait_oe_o), .nonarray_o(nonarray_o), .reset_in_n_i(reset_in_n_i));
